// ---- design/prom_programmer.sv ----
// Behaviour
// - Reset and clock low select programming mode
// - Raise program supply only with pins low
// - Chip-enable low pulse writes byte, 1 ms
// - Verify after pulse, retry up to 25
// - Over-program pulse three times accumulated time
// - Verify again, then advance address
// - Final full verify at normal supply
// - Array is 32K by 8, 1 ms pulse; code holds pin_addr[14] low, so only the low 16K is reached
// - Top address lines and spare inputs low
// - Interrupt input held high throughout
`timescale 1ns/1ps
`default_nettype none
module prom_programmer #(
  parameter int PULSE_CYCLES = prom_prog_pkg::PULSE_CYC,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [14:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic start_verify,
  output logic busy,
  output logic done,
  output logic fail,
  output logic [14:0] fail_addr,
  output logic [14:0] pin_addr,
  output logic [7:0] pin_data_out,
  output logic pin_data_oe,
  input wire logic [7:0] pin_data_in,
  output logic chip_en_n,
  output logic out_en_n,
  output logic reset_n,
  output logic clk_pin_out,
  output logic clk_pin_oe,
  output logic nmi_level,
  output logic core_supply_high,
  output logic prog_supply_high,
  output logic mode_active
);
  initial begin
    if (PULSE_CYCLES < 1) $error("PULSE_CYCLES must be at least 1");
  end
  // ****************************************
  // Request buffer
  // ****************************************
  logic [22:0] fifo_q;
  logic fifo_valid;
  logic fifo_pop;
  word_fifo #(.WIDTH(23), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_data({wr_addr, wr_data}),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_data(fifo_q),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );
  // ****************************************
  // Data pin synchroniser
  // ****************************************
  logic [7:0] din_meta;
  logic [7:0] din_sync;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      din_meta <= 8'h00;
      din_sync <= 8'h00;
    end else begin
      din_meta <= pin_data_in;
      din_sync <= din_meta;
    end
  end
  // ****************************************
  // Sequencer
  // ****************************************
  typedef enum logic [3:0] {
    ST_ENTER, ST_SETTLE, ST_IDLE, ST_SETUP, ST_PULSE, ST_READ, ST_CHECK,
    ST_OVER, ST_OVER_READ, ST_VLOWER, ST_VREAD, ST_VCHECK
  } state_t;
  state_t state;
  logic [31:0] timer;
  logic [4:0] tries;
  logic [14:0] cur_addr;
  logic [7:0] cur_data;
  logic [14:0] scan_addr;
  logic scan_pending;
  logic scan_bad;
  logic [7:0] expect_mem [32768];
  logic timer_done;
  assign timer_done = timer == 32'h0000_0000;
  assign fifo_pop = (state == ST_IDLE) && fifo_valid;
  always_ff @(posedge sys_clk) begin
    if (fifo_pop) begin
      expect_mem[fifo_q[22:8]] <= fifo_q[7:0];
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scan_pending <= 1'b0;
    end else if (start_verify) begin
      scan_pending <= 1'b1;
    end else if (state == ST_IDLE && !fifo_valid) begin
      scan_pending <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ST_ENTER;
      timer <= 32'h0000_0000;
      tries <= 5'h00;
      cur_addr <= 15'h0000;
      cur_data <= 8'h00;
      scan_addr <= 15'h0000;
      scan_bad <= 1'b0;
      done <= 1'b0;
      fail <= 1'b0;
      fail_addr <= 15'h0000;
    end else begin
      done <= 1'b0;
      if (!timer_done) begin
        timer <= timer - 32'h0000_0001;
      end
      case (state)
        ST_ENTER: begin
          state <= ST_SETTLE;
          timer <= 32'(prom_prog_pkg::SETTLE_CYC);
        end
        ST_SETTLE: begin
          if (timer_done) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (fifo_valid) begin
            cur_addr <= fifo_q[22:8];
            cur_data <= fifo_q[7:0];
            tries <= 5'h00;
            state <= ST_SETUP;
            timer <= 32'(prom_prog_pkg::ADDR_SETUP_CYC);
          end else if (scan_pending) begin
            scan_addr <= 15'h0000;
            scan_bad <= 1'b0;
            state <= ST_VLOWER;
            timer <= 32'(prom_prog_pkg::SETTLE_CYC);
          end
        end
        ST_SETUP: begin
          if (timer_done) begin
            state <= ST_PULSE;
            // State lasts one cycle longer than the count loaded
            timer <= 32'(PULSE_CYCLES - 1);
            tries <= tries + 5'h01;
          end
        end
        ST_PULSE: begin
          if (timer_done) begin
            state <= ST_READ;
            timer <= 32'(prom_prog_pkg::READ_CYC);
          end
        end
        ST_READ: begin
          if (timer_done) begin
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (din_sync == cur_data) begin
            state <= ST_OVER;
            timer <= 32'(prom_prog_pkg::OVER_FACTOR * PULSE_CYCLES) * 32'(tries) - 32'h0000_0001;
          end else if (tries >= 5'(prom_prog_pkg::MAX_TRIES)) begin
            fail <= 1'b1;
            fail_addr <= cur_addr;
            done <= 1'b1;
            state <= ST_IDLE;
          end else begin
            state <= ST_PULSE;
            timer <= 32'(PULSE_CYCLES - 1);
            tries <= tries + 5'h01;
          end
        end
        ST_OVER: begin
          if (timer_done) begin
            state <= ST_OVER_READ;
            timer <= 32'(prom_prog_pkg::READ_CYC);
          end
        end
        ST_OVER_READ: begin
          if (timer_done) begin
            if (din_sync != cur_data) begin
              fail <= 1'b1;
              fail_addr <= cur_addr;
            end
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_VLOWER: begin
          if (timer_done) begin
            state <= ST_VREAD;
            timer <= 32'(prom_prog_pkg::READ_CYC);
          end
        end
        ST_VREAD: begin
          if (timer_done) begin
            state <= ST_VCHECK;
          end
        end
        ST_VCHECK: begin
          if (din_sync != expect_mem[scan_addr] && !scan_bad) begin
            scan_bad <= 1'b1;
            fail <= 1'b1;
            fail_addr <= scan_addr;
          end
          if (scan_addr == prom_prog_pkg::LAST_ADDR) begin
            done <= 1'b1;
            state <= ST_IDLE;
          end else begin
            scan_addr <= scan_addr + 15'h0001;
            state <= ST_VREAD;
            timer <= 32'(prom_prog_pkg::READ_CYC);
          end
        end
        default: begin
          state <= ST_ENTER;
        end
      endcase
    end
  end
  // ****************************************
  // Pin drive, all registered
  // ****************************************
  logic verifying;
  logic reading;
  assign verifying = state == ST_VLOWER || state == ST_VREAD || state == ST_VCHECK;
  assign reading = state == ST_READ || state == ST_CHECK || state == ST_OVER_READ || verifying;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reset_n <= 1'b0;
      clk_pin_out <= 1'b0;
      clk_pin_oe <= 1'b1;
      nmi_level <= 1'b1;
      core_supply_high <= 1'b0;
      prog_supply_high <= 1'b0;
      mode_active <= 1'b0;
      busy <= 1'b0;
    end else begin
      reset_n <= 1'b0;
      clk_pin_out <= 1'b0;
      clk_pin_oe <= 1'b1;
      nmi_level <= 1'b1;
      mode_active <= state != ST_ENTER;
      core_supply_high <= state != ST_ENTER && !verifying;
      // Supply only raised after the mode pins have settled
      prog_supply_high <= state != ST_ENTER && state != ST_SETTLE && !verifying;
      busy <= state != ST_IDLE || fifo_valid || scan_pending;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_addr <= 15'h0000;
      pin_data_out <= 8'h00;
      pin_data_oe <= 1'b0;
      chip_en_n <= 1'b1;
      out_en_n <= 1'b1;
    end else begin
      // Highest line held low; addresses above it wrap
      pin_addr <= verifying ? {1'b0, scan_addr[13:0]} : {1'b0, cur_addr[13:0]};
      pin_data_out <= cur_data;
      pin_data_oe <= state == ST_SETUP || state == ST_PULSE || state == ST_OVER;
      chip_en_n <= !(state == ST_PULSE || state == ST_OVER || reading);
      out_en_n <= !reading;
    end
  end
endmodule
`default_nettype wire

// ---- design/prom_prog_pkg.sv ----
package prom_prog_pkg;
  // ****************************************
  // Array geometry
  // ****************************************
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam logic [14:0] LAST_ADDR = 15'h7FFF;
  // ****************************************
  // Timing (25 MHz, 40 ns period)
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int PULSE_US = 1000;
  localparam int PULSE_CYC = (PULSE_US * 1000) / CLK_PERIOD_NS;
  localparam int SUPPLY_SETTLE_US = 10;
  localparam int SETTLE_CYC = (SUPPLY_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_NS = 1100;
  localparam int READ_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_TRIES = 25;
  localparam int OVER_FACTOR = 3;
  localparam int ADDR_SETUP_CYC = 2;
endpackage

// ---- design/word_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  logic push;
  logic pop;
  assign in_ready = (wr_ptr - rd_ptr) != (PW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/prom_programmer_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module prom_programmer_assertions #(
  parameter int PULSE_CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic done,
  input wire logic [14:0] pin_addr,
  input wire logic [7:0] pin_data_out,
  input wire logic pin_data_oe,
  input wire logic chip_en_n,
  input wire logic out_en_n,
  input wire logic reset_n,
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe,
  input wire logic nmi_level,
  input wire logic core_supply_high,
  input wire logic prog_supply_high
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Write pulse measurement
  // ****************************************
  logic wr;
  logic wr_d;
  int width;
  int tries;
  // Chip-enable also drops during read-back, so only count it with output-enable high
  assign wr = !chip_en_n && out_en_n;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_d <= 1'b0;
      width <= 0;
    end else begin
      wr_d <= wr;
      width <= wr ? width + 1 : 0;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) tries <= 0;
    else if (done) tries <= 0;
    else if (wr_d && !wr && width == PULSE_CYCLES) tries <= tries + 1;
  end
  a_mode_pins_low: assert property (!reset_n && clk_pin_oe && !clk_pin_out)
    else $error("mode pins not held low");
  a_nmi_held_high: assert property (nmi_level)
    else $error("interrupt pin not held high");
  a_supply_order: assert property (prog_supply_high |-> core_supply_high && !reset_n)
    else $error("program supply raised without core supply");
  a_top_addr_low: assert property (pin_addr[14] == 1'b0)
    else $error("top address line not low");
  a_pulse_width: assert property (wr_d && !wr |->
    width == PULSE_CYCLES || width == 3 * tries * PULSE_CYCLES)
    else $error("write pulse of wrong length");
  a_write_steady: assert property (wr |-> pin_data_oe && $stable(pin_addr) && $stable(pin_data_out))
    else $error("address or data moved during write pulse");
  a_verify_follows: assert property (wr_d && !wr |-> ##[0:2] (!chip_en_n && !out_en_n))
    else $error("no read-back after write pulse");
  a_tries_limit: assert property (tries <= prom_prog_pkg::MAX_TRIES)
    else $error("too many write attempts");
  a_done_single: assert property (done |=> !done)
    else $error("done held longer than one cycle");
  c_short_pulse: cover property (wr_d && !wr && width == PULSE_CYCLES);
  c_all_tries: cover property (tries == prom_prog_pkg::MAX_TRIES);
  c_done: cover property (done);
endmodule
bind prom_programmer prom_programmer_assertions #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .sys_clk, .rst, .done, .pin_addr, .pin_data_out, .pin_data_oe, .chip_en_n, .out_en_n,
  .reset_n, .clk_pin_out, .clk_pin_oe, .nmi_level, .core_supply_high, .prog_supply_high);
`default_nettype wire

// ---- sim/prom_device_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module prom_device_model (
  input wire logic sys_clk,
  input wire logic [14:0] pin_addr,
  input wire logic [7:0] pin_data_out,
  input wire logic pin_data_oe,
  input wire logic chip_en_n,
  input wire logic out_en_n,
  input wire logic reset_n,
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe,
  input wire logic prog_supply_high,
  output logic [7:0] data_bus,
  output logic cpu_clk
);
  // ****************************************
  // Array and write behaviour
  // ****************************************
  logic [7:0] mem [0:32767];
  int need_tab [0:32767];
  int wcyc [0:32767];
  int hits [0:32767];
  logic [7:0] last = 8'h00;
  logic [7:0] latch = 8'h00;
  logic [1:0] div = 2'h0;
  logic wr_d = 1'b0;
  wire prog_mode = !reset_n && clk_pin_oe && !clk_pin_out;
  wire wr = prog_mode && prog_supply_high && !chip_en_n && out_en_n;
  wire drive = prog_mode && !chip_en_n && !out_en_n;
  initial begin
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 8'hFF;
      need_tab[i] = 1;
      wcyc[i] = 0;
      hits[i] = 0;
    end
  end
  // A stubborn cell only takes its byte after need_tab pulses
  always @(posedge sys_clk) begin
    last <= data_bus;
    div <= div + 2'h1;
    wr_d <= wr;
    if (wr) wcyc[pin_addr] <= wcyc[pin_addr] + 1;
    if (wr) latch <= pin_data_out;
    if (wr_d && !wr) begin
      hits[pin_addr] = hits[pin_addr] + 1;
      if (hits[pin_addr] >= need_tab[pin_addr]) mem[pin_addr] <= latch;
    end
  end
  // Released bus shows the inverse of its last level, never a stale match
  assign data_bus = pin_data_oe ? pin_data_out : (drive ? mem[pin_addr] : ~last);
  assign cpu_clk = reset_n ? div[1] : 1'b1;
endmodule
`default_nettype wire

// ---- sim/memory_program_mode_program_access_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module memory_program_mode_program_access_test;
  typedef struct packed {logic [14:0] addr; logic [7:0] data; int need;} note_t;
  logic sys_clk, rst, wr_valid, wr_ready, start_verify, busy, done, fail, pin_data_oe;
  logic chip_en_n, out_en_n, reset_n, clk_pin_out, clk_pin_oe, nmi_level;
  logic core_supply_high, prog_supply_high, mode_active, saw_full;
  logic [14:0] wr_addr, fail_addr, pin_addr;
  logic [7:0] wr_data, pin_data_out, pin_data_in;
  note_t notes[$];
  int fails = 0;
  int checks_done = 0;
  int seed = 88374;
  int needs[7] = '{1, 2, 3, 1, 25, 2, 26};
  prom_programmer #(.PULSE_CYCLES(4)) u_dut (.sys_clk, .rst, .wr_addr, .wr_data, .wr_valid,
    .wr_ready, .start_verify, .busy, .done, .fail, .fail_addr, .pin_addr, .pin_data_out,
    .pin_data_oe, .pin_data_in, .chip_en_n, .out_en_n, .reset_n, .clk_pin_out, .clk_pin_oe,
    .nmi_level, .core_supply_high, .prog_supply_high, .mode_active);
  prom_device_model u_dev (.sys_clk, .pin_addr, .pin_data_out, .pin_data_oe, .chip_en_n,
    .out_en_n, .reset_n, .clk_pin_out, .clk_pin_oe, .prog_supply_high,
    .data_bus(pin_data_in), .cpu_clk());
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (exp !== got) begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Request is held from a falling edge until the rising edge that sees ready
  task automatic push(input logic [14:0] a, input logic [7:0] d, input int n);
    int k = 0;
    u_dev.need_tab[a] = n;
    notes.push_back('{a, d, n});
    @(negedge sys_clk);
    wr_addr = a;
    wr_data = d;
    wr_valid = 1'b1;
    while (wr_ready !== 1'b1) begin
      saw_full = 1'b1;
      @(negedge sys_clk);
      k++;
      if (k > 20000) begin
        fails++;
        finish_test();
      end
    end
    @(posedge sys_clk);
  endtask
  // ****************************************
  // Result watcher
  // ****************************************
  initial begin
    note_t e;
    forever begin
      @(negedge sys_clk);
      if (done === 1'b1) begin
        if (notes.size() == 0) compare("spare done", 0, 1);
        else begin
          e = notes.pop_front();
          compare("fail", e.need > 25, fail);
          compare("cell", (e.need > 25) ? 8'hFF : e.data, u_dev.mem[e.addr]);
          compare("write time", (e.need > 25 ? 25 : 4 * e.need) * 4, u_dev.wcyc[e.addr]);
          if (e.need > 25) compare("fail addr", e.addr, fail_addr);
        end
      end
    end
  end
  initial begin
    int k = 0;
    rst = 1'b1;
    saw_full = 1'b0;
    wr_valid = 1'b0;
    wr_addr = 15'h0000;
    wr_data = 8'h00;
    start_verify = 1'b0;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    // Distinct low nibble keeps addresses apart; top bit clear keeps bytes off the erased value
    foreach (needs[i]) push(15'($random(seed)) & 15'h1FF0 | 15'(i), {1'b0, 7'($random(seed))}, needs[i]);
    @(negedge sys_clk);
    wr_valid = 1'b0;
    while ((notes.size() != 0 || busy !== 1'b0) && k < 40000) begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= 40000) fails++;
    compare("fifo refused", 1, saw_full);
    compare("busy idle", 0, busy);
    compare("mode active", 1, mode_active);
    compare("reset pin", 0, reset_n);
    compare("interrupt pin", 1, nmi_level);
    finish_test();
  end
endmodule
`default_nettype wire
